// *** sim/nid_checker_assertions.sv ***
/* checker for nid_node_phy_regs: phy requests and register reads.
   assumes one clock and sync active-high reset; bound below. */
module nid_checker (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [31:0] reg_rdata_out,
    input wire logic phy_reg_rx_in,
    input wire logic phy_req_ready_in,
    input wire logic phy_req_valid_out,
    input wire logic phy_req_write_out,
    input wire logic [3:0] phy_req_addr_out,
    input wire logic [7:0] phy_req_data_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);
    wire rd_id = reg_rd_in && reg_addr_in == 8'hE8;
    wire rd_phy = reg_rd_in && reg_addr_in == 8'hEC;
    wire set_req = reg_wr_in && reg_addr_in == 8'hEC
        && (reg_wdata_in[15] || reg_wdata_in[14]);
    req_hold_a: assert property (phy_req_valid_out && !phy_req_ready_in
        |=> phy_req_valid_out && $stable({phy_req_write_out,
        phy_req_addr_out, phy_req_data_out})) else $error("request not held");
    req_drop_a: assert property (phy_req_valid_out && phy_req_ready_in
        |=> !phy_req_valid_out) else $error("request not released");
    req_cause_a: assert property ($rose(phy_req_valid_out)
        |-> $past(set_req)) else $error("request without write");
    read_data_a: assert property (phy_req_valid_out && !phy_req_write_out
        |-> phy_req_data_out == 8'h00) else $error("read carries data");
    id_zero_a: assert property (rd_id |=> reg_rdata_out[29:28] == 2'h0
        && reg_rdata_out[26:16] == 11'h000) else $error("identity gap set");
    phy_zero_a: assert property (rd_phy |=> reg_rdata_out[30:28] == 3'h0
        && reg_rdata_out[13:12] == 2'h0) else $error("access gap set");
    done_set_a: assert property (phy_reg_rx_in ##2 rd_phy
        |=> reg_rdata_out[31]) else $error("complete not set");
    done_clear_a: assert property (set_req && !phy_req_valid_out
        && !phy_reg_rx_in ##1 !phy_reg_rx_in ##1 rd_phy && !phy_reg_rx_in
        |=> !reg_rdata_out[31]) else $error("complete not cleared");
endmodule // nid_checker

bind nid_node_phy_regs nid_checker chk (.*);

// *** sim/nid_phy_model.sv ***
/* behavioural phy: a register file answering link requests.
   assumes requests on mclk_in; stall_in holds ready low. */
module nid_phy_model (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic stall_in,
    input wire logic req_valid_in,
    input wire logic req_write_in,
    input wire logic [3:0] req_addr_in,
    input wire logic [7:0] req_data_in,
    output logic req_ready_out,
    output logic rx_out,
    output logic [3:0] rx_addr_out,
    output logic [7:0] rx_data_out
);
    logic [7:0] regs_reg [0:15];
    assign req_ready_out = !stall_in;
    always @(posedge mclk_in) begin
        rx_out <= 1'h0;
        // idle answer lines toggle so a stale value never passes
        rx_addr_out <= ~rx_addr_out;
        rx_data_out <= ~rx_data_out;
        if (sys_rst_in) begin
            rx_addr_out <= 4'h0;
            rx_data_out <= 8'h00;
            for (int i = 0; i < 16; i++) begin
                regs_reg[i] <= 8'hA0 | 8'(i);
            end
        end else if (req_valid_in && req_ready_out) begin
            if (req_write_in) begin
                regs_reg[req_addr_in] <= req_data_in;
            end else begin
                rx_out <= 1'h1;
                rx_addr_out <= req_addr_in;
                rx_data_out <= regs_reg[req_addr_in];
            end
        end
    end
endmodule // nid_phy_model

// *** sim/tb_top.sv ***
/* self-checking bench for nid_node_phy_regs with a phy model.
   assumes 125 MHz clock, sync reset, mask bit high enables. */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_in = 1'h0;
    logic sys_rst_in = 1'h1;
    logic [7:0] reg_addr_in = 8'h00;
    logic [31:0] reg_wdata_in = 32'h0;
    logic reg_wr_in = 1'h0;
    logic reg_rd_in = 1'h0;
    logic phy_bus_reset_in = 1'h0;
    logic phy_is_root_in = 1'h0;
    logic phy_cable_power_in = 1'h0;
    logic phy_node_valid_in = 1'h0;
    logic [5:0] phy_node_number_in = 6'h00;
    logic stall = 1'h0;
    wire [31:0] reg_rdata_out;
    wire phy_reg_rx_in, phy_req_ready_in, phy_req_valid_out;
    wire phy_req_write_out, irq_out;
    wire [3:0] phy_reg_rx_addr_in, phy_req_addr_out;
    wire [7:0] phy_reg_rx_data_in, phy_req_data_out;
    int err_total = 0;
    int check_count = 0;
    int rx_cnt = 0;
    int acc_cnt = 0;
    nid_node_phy_regs DUT (.*);
    nid_phy_model phy (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
        .stall_in(stall), .req_valid_in(phy_req_valid_out),
        .req_write_in(phy_req_write_out), .req_addr_in(phy_req_addr_out),
        .req_data_in(phy_req_data_out), .req_ready_out(phy_req_ready_in),
        .rx_out(phy_reg_rx_in), .rx_addr_out(phy_reg_rx_addr_in),
        .rx_data_out(phy_reg_rx_data_in));
    initial begin
        forever #4 mclk_in = ~mclk_in;
    end
    always @(posedge mclk_in) begin
        rx_cnt <= rx_cnt + int'(phy_reg_rx_in === 1'h1);
        acc_cnt <= acc_cnt + int'(phy_req_valid_out && phy_req_ready_in);
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'h1;
        @(posedge mclk_in);
        reg_wr_in <= 1'h0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, e);
        @(posedge mclk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'h1;
        @(posedge mclk_in);
        reg_rd_in <= 1'h0;
        #1 check(reg_rdata_out & m, e);
    endtask
    task automatic ev(input logic rst, input logic [5:0] num, input logic rt,
            input logic cp);
        @(posedge mclk_in);
        phy_bus_reset_in <= rst;
        phy_node_valid_in <= !rst;
        phy_node_number_in <= num;
        phy_is_root_in <= rt;
        phy_cable_power_in <= cp;
        @(posedge mclk_in);
        phy_bus_reset_in <= 1'h0;
        phy_node_valid_in <= 1'h0;
    endtask
    task automatic wait_cnt(input int rx_goal, input int acc_goal);
        for (int n = 0; rx_cnt < rx_goal || acc_cnt < acc_goal; n++) begin
            if (n == 40) begin
                err_total++;
                give_verdict();
            end
            @(posedge mclk_in);
            #1;
        end
    endtask
    initial begin
        repeat (4) @(posedge mclk_in);
        sys_rst_in <= 1'h0;
        rdc(8'hE8, 32'hFFFFFFFF, 32'h0000FFFF);
        rdc(8'hEC, 32'hFFFFFFFF, 32'h0);
        wr(8'h10, 32'hFFFFFFFF);
        rdc(8'h10, 32'hFFFFFFFF, 32'h0);
        wr(8'hE8, 32'hFFFFA5C3);
        rdc(8'hE8, 32'hFFFFFFFF, 32'h0000A5FF);
        ev(1'h1, 6'h00, 1'h1, 1'h1);
        rdc(8'hE8, 32'hFFFFFFC0, 32'h4800A5C0);
        ev(1'h0, 6'h05, 1'h1, 1'h1);
        rdc(8'hE8, 32'hFFFFFFFF, 32'hC800A5C5);
        ev(1'h1, 6'h00, 1'h0, 1'h0);
        rdc(8'hE8, 32'hFFFFFFC0, 32'h0000A5C0);
        ev(1'h0, 6'h3F, 1'h0, 1'h0); // no transmit run follows
        rdc(8'hE8, 32'hFFFFFFFF, 32'h8000A5FF);
        check(irq_out, 1'h0);
        wr(8'hFC, 32'h7);
        @(posedge mclk_in);
        #1 check(irq_out, 1'h1);
        rdc(8'hF8, 32'hFFFFFFFF, 32'h6);
        check(irq_out, 1'h0);
        $display("test identity done");
        wr(8'hEC, 32'h00008300);
        wait_cnt(1, 1);
        rdc(8'hEC, 32'hFFFFFFFF, 32'h83A30300);
        @(posedge mclk_in);
        stall <= 1'h1;
        wr(8'hEC, 32'h00004A5C);
        rdc(8'hEC, 32'hFFFFFFFF, 32'h03A34A5C);
        wr(8'hEC, 32'h00008100);
        rdc(8'hEC, 32'hFFFFFFFF, 32'h03A34A5C);
        check({phy_req_write_out, phy_req_addr_out, phy_req_data_out},
            13'h1A5C);
        @(posedge mclk_in);
        stall <= 1'h0;
        wait_cnt(1, 2);
        rdc(8'hEC, 32'hFFFFFFFF, 32'h03A30A5C);
        wr(8'hEC, 32'h00008A00);
        wait_cnt(2, 3);
        rdc(8'hEC, 32'hFFFFFFFF, 32'h8A5C0A00);
        check(acc_cnt, 32'h3);
        check(irq_out, 1'h1);
        rdc(8'hF8, 32'hFFFFFFFF, 32'h1);
        $display("test phy access done");
        give_verdict();
    end
endmodule // tb_top

// *** src/nid_defs.vh ***
/*
 * constants for the node identity and phy register access block:
 * register offsets, field positions, reset values.
 * assumes inclusion by bare name from the design file.
 */
`ifndef NID_DEFS_VH
`define NID_DEFS_VH

`define NID_OFS_NODE_IDENTITY 8'hE8
`define NID_OFS_PHY_ACCESS 8'hEC
`define NID_OFS_INT_STATUS 8'hF8
`define NID_OFS_INT_MASK 8'hFC

`define NID_BIT_ID_VALID 31
`define NID_BIT_ROOT 30
`define NID_BIT_CABLE_PWR 27
`define NID_BUS_HI 15
`define NID_BUS_LO 6
`define NID_NODE_HI 5
`define NID_NODE_LO 0

`define NID_BIT_RD_DONE 31
`define NID_RADDR_HI 27
`define NID_RADDR_LO 24
`define NID_RDATA_HI 23
`define NID_RDATA_LO 16
`define NID_BIT_RD_REQ 15
`define NID_BIT_WR_REQ 14
`define NID_TADDR_HI 11
`define NID_TADDR_LO 8
`define NID_WDATA_HI 7
`define NID_WDATA_LO 0

`define NID_BUS_RESET 10'h3FF
`define NID_NODE_RESET 6'h3F
`define NID_INT_BITS 3

`endif

// *** src/nid_node_phy_regs.v ***
/*
 * node identity register and phy register access mailbox, with a
 * small interrupt status/mask pair.
 * assumes a single clock mclk_in; phy-side status and events arrive
 * from link logic on the same clock (no synchronisers needed); the phy
 * request port accepts a request whenever ready is high.
 */
`include "nid_defs.vh"

// What this block does
// - node identifier is bus segment in 15-6 and node index in 5-0
// - valid flag clears on bus reset, sets when new node number arrives
// - root flag set during bus reset when phy reports root
// - cable power flag follows phy cable power good status
// - node identity bits 29-28 and 26-16 read as zero
// - bus segment number software writable, resets to all ones
// - node index loaded from phy after self-id, read only
// - read complete clears when software sets read or write request
// - read complete sets when phy register transfer arrives
// - returned address captured in bits 27-24
// - returned value captured in bits 23-16
// - software sets read request; hardware clears it once sent
// - software sets write request; hardware clears it once sent
// - target address sent always; write value only for writes
// - phy access bits 30-28 and 13-12 read as zero
module nid_node_phy_regs (
    input wire mclk_in,
    input wire sys_rst_in,
    input wire [7:0] reg_addr_in,
    input wire [31:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    output reg [31:0] reg_rdata_out,
    input wire phy_bus_reset_in,
    input wire phy_is_root_in,
    input wire phy_cable_power_in,
    input wire phy_node_valid_in,
    input wire [5:0] phy_node_number_in,
    input wire phy_reg_rx_in,
    input wire [3:0] phy_reg_rx_addr_in,
    input wire [7:0] phy_reg_rx_data_in,
    input wire phy_req_ready_in,
    output reg phy_req_valid_out,
    output reg phy_req_write_out,
    output reg [3:0] phy_req_addr_out,
    output reg [7:0] phy_req_data_out,
    output reg irq_out
);

    // node identity state
    reg id_valid_reg;
    reg root_reg;
    reg cable_pwr_reg;
    reg [9:0] bus_segment_number_reg;
    reg [5:0] physical_node_index_reg;
    // phy access mailbox state
    reg phy_read_complete_reg;
    reg [3:0] phy_returned_address_reg;
    reg [7:0] phy_returned_value_reg;
    reg phy_read_request_reg;
    reg phy_write_request_reg;
    reg [3:0] phy_target_address_reg;
    reg [7:0] phy_write_value_reg;
    // interrupt: 0 register transfer in, 1 node id valid, 2 bus reset
    reg [`NID_INT_BITS-1:0] int_status_reg;
    reg [`NID_INT_BITS-1:0] int_mask_reg;
    reg [`NID_INT_BITS-1:0] int_status_next;
    reg [31:0] rdata_next;

    // one-hot mailbox states
    localparam [1:0] MB_IDLE = 2'b01;
    localparam [1:0] MB_SEND = 2'b10;

    reg [1:0] mb_state_reg;
    reg [1:0] mb_state_next;
    // node identity next values
    reg id_valid_next;
    reg root_next;
    reg cable_pwr_next;
    reg [9:0] bus_segment_number_next;
    reg [5:0] physical_node_index_next;
    // output port next values
    reg phy_req_valid_next;
    reg phy_req_write_next;
    reg [3:0] phy_req_addr_next;
    reg [7:0] phy_req_data_next;
    reg irq_next;
    reg [31:0] reg_rdata_next;

    // true when the strobe hits the given offset
    function hit;
        input strobe;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            hit = strobe && (addr == ofs);
        end
    endfunction

    wire wr_phy = hit(reg_wr_in, reg_addr_in, `NID_OFS_PHY_ACCESS);
    wire wr_node = hit(reg_wr_in, reg_addr_in, `NID_OFS_NODE_IDENTITY);
    wire wr_mask = hit(reg_wr_in, reg_addr_in, `NID_OFS_INT_MASK);
    wire rd_status = hit(reg_rd_in, reg_addr_in, `NID_OFS_INT_STATUS);
    // only one request in flight: later requests are ignored until idle, though a request bit still clears read complete
    wire mb_idle = mb_state_reg[0];
    wire req_taken = phy_req_valid_out && phy_req_ready_in;
    wire sw_rd_set = wr_phy && reg_wdata_in[`NID_BIT_RD_REQ];
    wire sw_wr_set = wr_phy && reg_wdata_in[`NID_BIT_WR_REQ];

    function [31:0] node_word;
        input v;
        input r;
        input c;
        input [9:0] bus;
        input [5:0] node;
        begin
            node_word = 32'h0000_0000;
            node_word[`NID_BIT_ID_VALID] = v;
            node_word[`NID_BIT_ROOT] = r;
            node_word[`NID_BIT_CABLE_PWR] = c;
            node_word[`NID_BUS_HI:`NID_BUS_LO] = bus;
            node_word[`NID_NODE_HI:`NID_NODE_LO] = node;
        end
    endfunction

    function [31:0] phy_word;
        input done;
        input [3:0] raddr;
        input [7:0] rval;
        input rreq;
        input wreq;
        input [3:0] taddr;
        input [7:0] wval;
        begin
            phy_word = 32'h0000_0000;
            phy_word[`NID_BIT_RD_DONE] = done;
            phy_word[`NID_RADDR_HI:`NID_RADDR_LO] = raddr;
            phy_word[`NID_RDATA_HI:`NID_RDATA_LO] = rval;
            phy_word[`NID_BIT_RD_REQ] = rreq;
            phy_word[`NID_BIT_WR_REQ] = wreq;
            phy_word[`NID_TADDR_HI:`NID_TADDR_LO] = taddr;
            phy_word[`NID_WDATA_HI:`NID_WDATA_LO] = wval;
        end
    endfunction

    // node identity
    always @* begin
        id_valid_next = id_valid_reg;
        root_next = root_reg;
        cable_pwr_next = phy_cable_power_in;
        bus_segment_number_next = bus_segment_number_reg;
        physical_node_index_next = physical_node_index_reg;
        if (wr_node) begin
            bus_segment_number_next =
                reg_wdata_in[`NID_BUS_HI:`NID_BUS_LO];
        end
        // bus reset wins over a node number in the same cycle
        if (phy_bus_reset_in) begin
            id_valid_next = 1'b0;
            root_next = phy_is_root_in;
        end else if (phy_node_valid_in) begin
            id_valid_next = 1'b1;
            physical_node_index_next = phy_node_number_in;
        end
    end

    always @(posedge mclk_in) begin
        if (sys_rst_in) begin
            id_valid_reg <= 1'b0;
            root_reg <= 1'b0;
            cable_pwr_reg <= 1'b0;
            bus_segment_number_reg <= `NID_BUS_RESET;
            physical_node_index_reg <= `NID_NODE_RESET;
        end else begin
            id_valid_reg <= id_valid_next;
            root_reg <= root_next;
            cable_pwr_reg <= cable_pwr_next;
            bus_segment_number_reg <= bus_segment_number_next;
            physical_node_index_reg <= physical_node_index_next;
        end
    end

    // mailbox state: idle until software asks, send until taken
    always @* begin
        mb_state_next = mb_state_reg;
        case (mb_state_reg)
            MB_IDLE: begin
                if (sw_rd_set || sw_wr_set) begin
                    mb_state_next = MB_SEND;
                end
            end
            MB_SEND: begin
                if (req_taken) begin
                    mb_state_next = MB_IDLE;
                end
            end
            default: begin
                mb_state_next = MB_IDLE;
            end
        endcase
    end

    // request port: outputs held stable until the phy takes them
    always @* begin
        phy_req_valid_next = phy_req_valid_out;
        phy_req_write_next = phy_req_write_out;
        phy_req_addr_next = phy_req_addr_out;
        phy_req_data_next = phy_req_data_out;
        if (req_taken) begin
            phy_req_valid_next = 1'b0;
        end
        if (mb_idle && (sw_rd_set || sw_wr_set)) begin
            phy_req_valid_next = 1'b1;
            phy_req_write_next = !sw_rd_set;
            phy_req_addr_next =
                reg_wdata_in[`NID_TADDR_HI:`NID_TADDR_LO];
            // reads carry zero data: the value is not sent
            phy_req_data_next = sw_rd_set ? 8'h00 :
                reg_wdata_in[`NID_WDATA_HI:`NID_WDATA_LO];
        end
    end

    // phy access mailbox
    always @(posedge mclk_in) begin
        if (sys_rst_in) begin
            phy_read_complete_reg <= 1'b0;
            phy_returned_address_reg <= 4'h0;
            phy_returned_value_reg <= 8'h00;
            phy_read_request_reg <= 1'b0;
            phy_write_request_reg <= 1'b0;
            phy_target_address_reg <= 4'h0;
            phy_write_value_reg <= 8'h00;
            phy_req_valid_out <= 1'b0;
            phy_req_write_out <= 1'b0;
            phy_req_addr_out <= 4'h0;
            phy_req_data_out <= 8'h00;
            mb_state_reg <= MB_IDLE;
        end else begin
            mb_state_reg <= mb_state_next;
            phy_req_valid_out <= phy_req_valid_next;
            phy_req_write_out <= phy_req_write_next;
            phy_req_addr_out <= phy_req_addr_next;
            phy_req_data_out <= phy_req_data_next;
            // arriving transfer wins over the software clear
            if (phy_reg_rx_in) begin
                phy_read_complete_reg <= 1'b1;
                phy_returned_address_reg <= phy_reg_rx_addr_in;
                phy_returned_value_reg <= phy_reg_rx_data_in;
            end else if (sw_rd_set || sw_wr_set) begin
                phy_read_complete_reg <= 1'b0;
            end
            if (req_taken) begin
                phy_read_request_reg <= 1'b0;
                phy_write_request_reg <= 1'b0;
            end
            // a new request is held off while one is still outstanding;
            // read request takes priority if software sets both
            if (wr_phy && mb_idle) begin
                phy_target_address_reg <=
                    reg_wdata_in[`NID_TADDR_HI:`NID_TADDR_LO];
                phy_write_value_reg <=
                    reg_wdata_in[`NID_WDATA_HI:`NID_WDATA_LO];
                if (sw_rd_set || sw_wr_set) begin
                    phy_read_request_reg <= sw_rd_set;
                    phy_write_request_reg <= !sw_rd_set;
                end
            end
        end
    end

    // interrupt status: set wins over read-to-clear
    always @* begin
        int_status_next = int_status_reg;
        if (rd_status) begin
            int_status_next = {`NID_INT_BITS{1'b0}};
        end
        if (phy_reg_rx_in) begin
            int_status_next[0] = 1'b1;
        end
        if (phy_node_valid_in && !phy_bus_reset_in) begin
            int_status_next[1] = 1'b1;
        end
        if (phy_bus_reset_in) begin
            int_status_next[2] = 1'b1;
        end
    end

    // uses the next status so irq drops with the clearing read
    always @* begin
        irq_next = |(int_status_next & int_mask_reg);
    end

    always @(posedge mclk_in) begin
        if (sys_rst_in) begin
            int_status_reg <= {`NID_INT_BITS{1'b0}};
            int_mask_reg <= {`NID_INT_BITS{1'b0}};
            irq_out <= 1'b0;
        end else begin
            int_status_reg <= int_status_next;
            if (wr_mask) begin
                int_mask_reg <= reg_wdata_in[`NID_INT_BITS-1:0];
            end
            irq_out <= irq_next;
        end
    end

    // read mux; unmapped addresses answer zero
    always @* begin
        rdata_next = 32'h0000_0000;
        case (reg_addr_in)
            `NID_OFS_NODE_IDENTITY: begin
                rdata_next = node_word(id_valid_reg, root_reg,
                    cable_pwr_reg, bus_segment_number_reg,
                    physical_node_index_reg);
            end
            `NID_OFS_PHY_ACCESS: begin
                rdata_next = phy_word(phy_read_complete_reg,
                    phy_returned_address_reg, phy_returned_value_reg,
                    phy_read_request_reg, phy_write_request_reg,
                    phy_target_address_reg, phy_write_value_reg);
            end
            `NID_OFS_INT_STATUS: begin
                rdata_next[`NID_INT_BITS-1:0] = int_status_reg;
            end
            `NID_OFS_INT_MASK: begin
                rdata_next[`NID_INT_BITS-1:0] = int_mask_reg;
            end
            default: begin
                rdata_next = 32'h0000_0000;
            end
        endcase
    end

    // read data stand one cycle only, zero otherwise
    always @* begin
        reg_rdata_next = 32'h0000_0000;
        if (reg_rd_in) begin
            reg_rdata_next = rdata_next;
        end
    end

    always @(posedge mclk_in) begin
        if (sys_rst_in) begin
            reg_rdata_out <= 32'h0000_0000;
        end else begin
            reg_rdata_out <= reg_rdata_next;
        end
    end

endmodule // nid_node_phy_regs
